// >>> verilog/usp_cfg.svh
`ifndef USP_CFG_SVH
`define USP_CFG_SVH

// Register byte offsets on the AXI4-Lite bus.
`define USP_OFS_MODEM_CTRL 8'h00
`define USP_OFS_ADD_CTRL 8'h04
`define USP_OFS_CLK_SEL 8'h08
`define USP_OFS_RATIO 8'h0c
`define USP_OFS_DIVISOR 8'h10
`define USP_OFS_THRESH 8'h14
`define USP_OFS_TX_DATA 8'h18
`define USP_OFS_FLOW_CHAR 8'h1c
`define USP_OFS_STATUS 8'h20
`define USP_OFS_FLOW_CTRL 8'h24

// Bit positions in modem_control_reg.
`define USP_MC_DTR 0
`define USP_MC_RTS 1
`define USP_MC_IRDA 6

// Bit positions in the flow control register.
`define USP_FC_ENH 0
`define USP_FC_AUTO_RTS 1
`define USP_FC_AUTO_CTS 2
`define USP_FC_AUTO_DSR 3
`define USP_FC_AUTO_DTR 4

// Direction control field of additional_control_reg.
`define USP_AC_485_EN 4
`define USP_AC_485_INV 3

// Fields of clock_select_reg.
`define USP_CS_RXSEL_HI 1
`define USP_CS_RXSEL_LO 0
`define USP_CS_BAUD_OFF 2
`define USP_CS_TXOUT_HI 5
`define USP_CS_TXOUT_LO 4
`define USP_CS_TX_EXT 6

// Encodings of the receive clock and transmit clock output fields.
`define USP_RXSEL_RCLK 2'h0
`define USP_RXSEL_DSR 2'h1
`define USP_RXSEL_BAUD 2'h2
`define USP_RXSEL_TX 2'h3
`define USP_TXOUT_ONEX 2'h1
`define USP_TXOUT_NX 2'h2

// Reset values.
`define USP_RST_BYTE 8'h00
`define USP_RST_RATIO 5'h10
`define USP_RST_DIVISOR 16'h0001
`define USP_RST_THR_UP 8'h60
`define USP_RST_THR_LO 8'h20

// Character timing and limits.
`define USP_RATIO_MIN 5'h02
`define USP_IRDA_PULSE 5'h03
`define USP_LAST_BIT 4'h9

// AXI response codes.
`define USP_RESP_OKAY 2'h0
`define USP_RESP_SLVERR 2'h2

`endif

// >>> verilog/usp_pkg.sv
package usp_pkg;

    // Transmitter sequencing states.
    typedef enum logic [0:0] {
        USP_TX_IDLE = 1'b0,
        USP_TX_SHIFT = 1'b1
    } usp_tx_e;

    // Serial and modem pins arriving from the line side.
    typedef struct packed {
        logic rx_serial_in;
        logic clear_to_send_n;
        logic data_set_ready_n;
        logic carrier_detect_n;
        logic ring_indicator_n;
        logic rclk;
    } usp_pins_in_s;

    // Serial and modem pins driven toward the line side.
    typedef struct packed {
        logic tx_serial_out;
        logic request_to_send_n;
        logic terminal_ready_n;
        logic baud_clock_out_n;
        logic baud_clock_out_oe;
    } usp_pins_out_s;

endpackage : usp_pkg

// >>> verilog/usp_pin_sync.sv
`timescale 1ns/10ps
module usp_pin_sync #(
    parameter int W = 6
) (
    // Clock, reset and clock enable.
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Asynchronous pins and their synchronised forms.
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);

    logic [W-1:0] stage1;
    logic [W-1:0] last;

    // Two flip-flops per pin, then one more stage to find rising edges.
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    stage1[i] <= 1'h1;
                    level[i] <= 1'h1;
                    last[i] <= 1'h1;
                end else if (ce) begin
                    stage1[i] <= pin[i];
                    level[i] <= stage1[i];
                    last[i] <= level[i];
                end
            end
            assign rise[i] = level[i] & ~last[i];
        end
    endgenerate

endmodule : usp_pin_sync

// >>> verilog/usp_serial_pin_ctrl.sv
`timescale 1ns/10ps
`include "usp_cfg.svh"
// Behaviour
// - Serial data drives transmit pin normally.
// - Infrared mode encodes transmit pin output.
// - Infrared mode decodes receive pin input.
// - Request pin drops at upper, returns below lower.
// - Ready pin asserts at upper, releases below lower.
// - Ready pin follows transmitter empty for RS-485.
// - Ready pin carries transmit clock when selected.
// - Clear input inactive stalls after current character.
// - Set-ready input inactive stalls after current character.
// - Flow characters ignore hardware flow stall.
// - Receive clock from set-ready pin on 01.
// - Ring pin clocks transmitter when selected.
// - Baud generator drives active-low baud pin.
// - Receive clock from baud generator on 10.
// - Baud pin released when routed and disabled.
module usp_serial_pin_ctrl (
    // Clock, reset and clock enable.
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address channel.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data channel.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address channel.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data channel.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial and modem pins.
    input wire usp_pkg::usp_pins_in_s pins_in,
    output usp_pkg::usp_pins_out_s pins_out,
    // Receive side of the port and transmitter empty status.
    input wire logic [7:0] rx_fifo_level,
    output logic rx_serial_data,
    output logic rx_clk_tick,
    output logic tx_empty
);

    // Software visible state.
    logic [7:0] modem_control_reg, additional_control_reg, clock_select_reg, flow_control_reg;
    logic [7:0] thr_upper, thr_lower, tx_data_buf, flow_char_buf;
    logic [4:0] sample_clock_ratio_reg, ratio_eff, tx_sub;
    logic [15:0] divisor_reg, baud_cnt, div_eff;
    logic data_pend, flow_pend;

    // Bus handshake state.
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, wr_word;
    logic [3:0] wstrb_q;
    logic aw_hold, w_hold, wr_go;

    // Pin synchroniser outputs.
    usp_pkg::usp_pins_in_s pin_lvl, pin_rise;

    // Baud generator and transmitter state.
    logic baud_tick, baud_lvl, tx_tick, tx_stall, irda_on, tx_bit, tx_load, rts_hold, dtr_hold;
    logic [1:0] rx_sel;
    usp_pkg::usp_tx_e tx_state;
    logic [9:0] tx_shift;
    logic [3:0] tx_bit_idx;

    // Decodes whether a byte address holds a register; the map is contiguous and word aligned.
    function automatic logic usp_mapped(input logic [7:0] a);
        usp_mapped = (a <= `USP_OFS_FLOW_CTRL) && (a[1:0] == 2'h0);
    endfunction : usp_mapped

    // Returns the word a register shows at a byte address; reserved bits read zero.
    function automatic logic [31:0] usp_reg_word(input logic [7:0] a);
        case (a)
            `USP_OFS_MODEM_CTRL: usp_reg_word = 32'(modem_control_reg);
            `USP_OFS_ADD_CTRL: usp_reg_word = 32'(additional_control_reg);
            `USP_OFS_CLK_SEL: usp_reg_word = 32'(clock_select_reg);
            `USP_OFS_RATIO: usp_reg_word = 32'(sample_clock_ratio_reg);
            `USP_OFS_DIVISOR: usp_reg_word = 32'(divisor_reg);
            `USP_OFS_THRESH: usp_reg_word = 32'({thr_lower, thr_upper});
            `USP_OFS_TX_DATA: usp_reg_word = 32'(tx_data_buf);
            `USP_OFS_FLOW_CHAR: usp_reg_word = 32'(flow_char_buf);
            `USP_OFS_STATUS: usp_reg_word = {16'h0000, rx_fifo_level, pin_lvl.ring_indicator_n,
                pin_lvl.carrier_detect_n, pin_lvl.data_set_ready_n, pin_lvl.clear_to_send_n,
                tx_stall, flow_pend, data_pend, tx_empty};
            `USP_OFS_FLOW_CTRL: usp_reg_word = 32'(flow_control_reg);
            default: usp_reg_word = 32'h00000000;
        endcase
    endfunction : usp_reg_word

    // Merges written bytes into the old word under the byte strobes.
    function automatic logic [31:0] usp_merge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        usp_merge = (old & ~m) | (data & m);
    endfunction : usp_merge

    // Hysteresis on the fill level: one pin value at the upper mark, the other below the lower.
    function automatic logic usp_hyst(input logic cur, input logic [7:0] lvl, input logic [7:0] up,
                                      input logic [7:0] low, input logic at_up);
        usp_hyst = (lvl >= up) ? at_up : ((lvl < low) ? ~at_up : cur);
    endfunction : usp_hyst

    // Every line-side input passes two flip-flops before use.
    usp_pin_sync #(
        .W(6)
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .pin(pins_in),
        .level(pin_lvl),
        .rise(pin_rise)
    );

    // Write channel: address and data taken in either order, response after both.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            aw_hold <= 1'h0;
            w_hold <= 1'h0;
            s_axi_awready <= 1'h0;
            s_axi_wready <= 1'h0;
            s_axi_bvalid <= 1'h0;
            s_axi_bresp <= `USP_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                aw_hold <= 1'h1;
                s_axi_awready <= 1'h0;
            end else if (!aw_hold && !s_axi_bvalid) begin
                s_axi_awready <= 1'h1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_hold <= 1'h1;
                s_axi_wready <= 1'h0;
            end else if (!w_hold && !s_axi_bvalid) begin
                s_axi_wready <= 1'h1;
            end
            if (wr_go) begin
                aw_hold <= 1'h0;
                w_hold <= 1'h0;
                s_axi_bvalid <= 1'h1;
                s_axi_bresp <= usp_mapped(awaddr_q) ? `USP_RESP_OKAY : `USP_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'h0;
            end
        end
    end

    // The register write happens in the cycle both halves are held.
    assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
    assign wr_word = usp_merge(usp_reg_word(awaddr_q), wdata_q, wstrb_q);

    // Read channel: one cycle from address to data; unmapped addresses answer SLVERR.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid <= 1'h0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `USP_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'h0;
                s_axi_rvalid <= 1'h1;
                s_axi_rdata <= usp_reg_word(s_axi_araddr);
                s_axi_rresp <= usp_mapped(s_axi_araddr) ? `USP_RESP_OKAY : `USP_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'h0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'h1;
            end
        end
    end

    // Control registers written by software.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            modem_control_reg <= `USP_RST_BYTE;
            additional_control_reg <= `USP_RST_BYTE;
            clock_select_reg <= `USP_RST_BYTE;
            flow_control_reg <= `USP_RST_BYTE;
            sample_clock_ratio_reg <= `USP_RST_RATIO;
            divisor_reg <= `USP_RST_DIVISOR;
            thr_upper <= `USP_RST_THR_UP;
            thr_lower <= `USP_RST_THR_LO;
            tx_data_buf <= `USP_RST_BYTE;
            flow_char_buf <= `USP_RST_BYTE;
        end else if (ce && wr_go) begin
            case (awaddr_q)
                `USP_OFS_MODEM_CTRL: modem_control_reg <= wr_word[7:0];
                `USP_OFS_ADD_CTRL: additional_control_reg <= wr_word[7:0];
                `USP_OFS_CLK_SEL: clock_select_reg <= wr_word[7:0];
                `USP_OFS_RATIO: sample_clock_ratio_reg <= wr_word[4:0];
                `USP_OFS_DIVISOR: divisor_reg <= wr_word[15:0];
                `USP_OFS_THRESH: {thr_lower, thr_upper} <= wr_word[15:0];
                `USP_OFS_TX_DATA: tx_data_buf <= wr_word[7:0];
                `USP_OFS_FLOW_CHAR: flow_char_buf <= wr_word[7:0];
                `USP_OFS_FLOW_CTRL: flow_control_reg <= wr_word[7:0];
                default: ;
            endcase
        end
    end

    // Pending flags: a new write wins over the load that clears the flag.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_pend <= 1'h0;
            flow_pend <= 1'h0;
        end else if (ce) begin
            if (tx_load && flow_pend) begin
                flow_pend <= 1'h0;
            end else if (tx_load) begin
                data_pend <= 1'h0;
            end
            if (wr_go && awaddr_q == `USP_OFS_TX_DATA && wstrb_q[0]) begin
                data_pend <= 1'h1;
            end
            if (wr_go && awaddr_q == `USP_OFS_FLOW_CHAR && wstrb_q[0]) begin
                flow_pend <= 1'h1;
            end
        end
    end

    // Baud generator: one Nx tick per divisor period, divisor zero acts as one.
    assign div_eff = (divisor_reg == 16'h0000) ? 16'h0001 : divisor_reg;
    assign baud_tick = (baud_cnt == div_eff - 16'h0001);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            baud_cnt <= 16'h0000;
            baud_lvl <= 1'h0;
        end else if (ce) begin
            baud_cnt <= baud_tick ? 16'h0000 : baud_cnt + 16'h0001;
            baud_lvl <= (baud_cnt < {1'h0, div_eff[15:1]});
        end
    end

    // Transmit clock source, character timing and flow control stall.
    assign tx_tick = clock_select_reg[`USP_CS_TX_EXT] ? pin_rise.ring_indicator_n : baud_tick;
    assign ratio_eff = (sample_clock_ratio_reg < `USP_RATIO_MIN) ? `USP_RATIO_MIN : sample_clock_ratio_reg;
    assign tx_stall = (flow_control_reg[`USP_FC_AUTO_CTS] & pin_lvl.clear_to_send_n)
        | (flow_control_reg[`USP_FC_AUTO_DSR] & pin_lvl.data_set_ready_n);
    assign tx_load = (tx_state == usp_pkg::USP_TX_IDLE) && tx_tick && (tx_sub == ratio_eff - 5'h01)
        && (flow_pend || (data_pend && !tx_stall));
    assign tx_bit = (tx_state == usp_pkg::USP_TX_SHIFT) ? tx_shift[0] : 1'h1;
    assign irda_on = flow_control_reg[`USP_FC_ENH] & modem_control_reg[`USP_MC_IRDA];
    assign rx_sel = clock_select_reg[`USP_CS_RXSEL_HI:`USP_CS_RXSEL_LO];

    // Transmitter: start, eight data bits and stop, each bit lasting ratio ticks.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state <= usp_pkg::USP_TX_IDLE;
            tx_shift <= 10'h3ff;
            tx_bit_idx <= 4'h0;
            tx_sub <= 5'h00;
        end else if (ce && tx_tick) begin
            tx_sub <= (tx_sub >= ratio_eff - 5'h01) ? 5'h00 : tx_sub + 5'h01;
            case (tx_state)
                usp_pkg::USP_TX_IDLE: begin
                    if (tx_load) begin
                        tx_shift <= {1'h1, flow_pend ? flow_char_buf : tx_data_buf, 1'h0};
                        tx_bit_idx <= 4'h0;
                        tx_state <= usp_pkg::USP_TX_SHIFT;
                    end
                end
                usp_pkg::USP_TX_SHIFT: begin
                    if (tx_sub >= ratio_eff - 5'h01) begin
                        if (tx_bit_idx == `USP_LAST_BIT) begin
                            tx_state <= usp_pkg::USP_TX_IDLE;
                        end else begin
                            tx_bit_idx <= tx_bit_idx + 4'h1;
                            tx_shift <= {1'h1, tx_shift[9:1]};
                        end
                    end
                end
                default: tx_state <= usp_pkg::USP_TX_IDLE;
            endcase
        end
    end

    // Hysteresis state for automatic request and ready flow control.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rts_hold <= 1'h0;
            dtr_hold <= 1'h1;
        end else if (ce) begin
            rts_hold <= usp_hyst(rts_hold, rx_fifo_level, thr_upper, thr_lower, 1'h1);
            dtr_hold <= usp_hyst(dtr_hold, rx_fifo_level, thr_upper, thr_lower, 1'h0);
        end
    end

    // Transmit data and request pins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_out.tx_serial_out <= 1'h1;
            pins_out.request_to_send_n <= 1'h1;
        end else if (ce) begin
            pins_out.tx_serial_out <= irda_on ? (!tx_bit && (tx_sub < `USP_IRDA_PULSE)) : tx_bit;
            pins_out.request_to_send_n <= flow_control_reg[`USP_FC_AUTO_RTS] ? rts_hold
                : ~modem_control_reg[`USP_MC_RTS];
        end
    end

    // Terminal-ready pin: clock output first, then RS-485 direction, then flow control.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_out.terminal_ready_n <= 1'h1;
        end else if (ce) begin
            case (clock_select_reg[`USP_CS_TXOUT_HI:`USP_CS_TXOUT_LO])
                `USP_TXOUT_ONEX: pins_out.terminal_ready_n <= (tx_sub < {1'h0, ratio_eff[4:1]});
                `USP_TXOUT_NX: pins_out.terminal_ready_n <= clock_select_reg[`USP_CS_TX_EXT]
                    ? pin_lvl.ring_indicator_n : baud_lvl;
                default: pins_out.terminal_ready_n <= additional_control_reg[`USP_AC_485_EN]
                    ? (tx_empty ^ additional_control_reg[`USP_AC_485_INV])
                    : (flow_control_reg[`USP_FC_AUTO_DTR] ? dtr_hold : ~modem_control_reg[`USP_MC_DTR]);
            endcase
        end
    end

    // Baud clock pin, released when routed inside and disabled.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_out.baud_clock_out_n <= 1'h1;
            pins_out.baud_clock_out_oe <= 1'h1;
        end else if (ce) begin
            pins_out.baud_clock_out_n <= ~baud_lvl;
            pins_out.baud_clock_out_oe <= !(rx_sel == `USP_RXSEL_BAUD && clock_select_reg[`USP_CS_BAUD_OFF]);
        end
    end

    // Receive clock selection, receive data decoding and transmitter empty status.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_clk_tick <= 1'h0;
            rx_serial_data <= 1'h1;
            tx_empty <= 1'h1;
        end else if (ce) begin
            case (rx_sel)
                `USP_RXSEL_RCLK: rx_clk_tick <= pin_rise.rclk;
                `USP_RXSEL_DSR: rx_clk_tick <= pin_rise.data_set_ready_n;
                `USP_RXSEL_BAUD: rx_clk_tick <= baud_tick;
                default: rx_clk_tick <= tx_tick;
            endcase
            rx_serial_data <= irda_on ? ~pin_lvl.rx_serial_in : pin_lvl.rx_serial_in;
            tx_empty <= (tx_state == usp_pkg::USP_TX_IDLE) && !tx_load && !data_pend && !flow_pend;
        end
    end

endmodule : usp_serial_pin_ctrl

// >>> verilog/usp_pkg_order_note.sv
`timescale 1ns/10ps

// >>> testbench/usp_spc_assertions.sv
`timescale 1ns/10ps
`include "usp_cfg.svh"
module usp_spc_assertions (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register write channels.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    // Pins and status.
    input wire usp_pkg::usp_pins_out_s pins_out,
    input wire logic [7:0] rx_fifo_level,
    input wire logic tx_empty
);
    logic [6:0] fc;
    logic [6:0] cs;
    wire wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    default clocking cb @(posedge aclk); endclocking
    // Shadows of the flow control and clock select registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fc <= 7'h00;
            cs <= 7'h00;
        end else if (wr && s_axi_awaddr == `USP_OFS_FLOW_CTRL) begin
            fc <= s_axi_wdata[6:0];
        end else if (wr && s_axi_awaddr == `USP_OFS_CLK_SEL) begin
            cs <= s_axi_wdata[6:0];
        end
    end
    a_rst_tx_idle: assert property (!aresetn |=> pins_out.tx_serial_out && tx_empty)
        else $error("tx pin busy in reset");
    a_rst_baud_pin: assert property (!aresetn |=> pins_out.baud_clock_out_n && pins_out.baud_clock_out_oe)
        else $error("baud pin in reset");
    a_rst_flow_pins: assert property (!aresetn |=> pins_out.request_to_send_n && pins_out.terminal_ready_n)
        else $error("flow pins in reset");
    a_rts_drop: assert property (disable iff (!aresetn) (fc[1] && rx_fifo_level >= `USP_RST_THR_UP) [*6]
        |-> pins_out.request_to_send_n) else $error("rts kept at upper");
    a_rts_back: assert property (disable iff (!aresetn) (fc[1] && rx_fifo_level < `USP_RST_THR_LO) [*6]
        |-> !pins_out.request_to_send_n) else $error("rts not back");
    a_dtr_set: assert property (disable iff (!aresetn) (fc[4] && rx_fifo_level >= `USP_RST_THR_UP) [*6]
        |-> !pins_out.terminal_ready_n) else $error("dtr not set at upper");
    a_baud_off: assert property (disable iff (!aresetn) (cs[1:0] == 2'h2 && cs[2]) [*6]
        |-> !pins_out.baud_clock_out_oe) else $error("baud pin driven");
    a_baud_on: assert property (disable iff (!aresetn) !(cs[1:0] == 2'h2 && cs[2]) [*6]
        |-> pins_out.baud_clock_out_oe) else $error("baud pin not driven");
endmodule : usp_spc_assertions
bind usp_serial_pin_ctrl usp_spc_assertions u_chk (.*);

// >>> testbench/usp_line_model.sv
`timescale 1ns/10ps
module usp_line_model (
    // Block clock and serial data from the block.
    input wire logic aclk,
    input wire logic tx_line,
    // Pins driven toward the block.
    output usp_pkg::usp_pins_in_s pins
);
    logic rxd = 1'b1, cts_n = 1'b0, dsr_n = 1'b0, dsel = 1'b0, ck = 1'b0;
    logic [7:0] got = 8'h00;
    int n = 0;
    // Spare modem lines idle high; the link clock rides on one pin.
    assign pins = {rxd, cts_n, dsr_n ^ (ck & dsel), 1'b1, 1'b1, ck & ~dsel};
    // Samples each bit mid-cell at sixteen block clocks a bit.
    always @(negedge tx_line) begin
        repeat (24) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            got[i] = tx_line;
            repeat (16) @(posedge aclk);
        end
        n++;
    end
    // Eight cycles of the external Nx clock, still between bursts.
    task automatic burst();
        repeat (8) begin
            #62.5 ck = 1'b1;
            #62.5 ck = 1'b0;
        end
    endtask : burst
endmodule : usp_line_model

// >>> testbench/tb_uart_serial_pin_control.sv
`timescale 1ns/10ps
module tb_uart_serial_pin_control;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_fifo_level = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic rx_serial_data, rx_clk_tick, tx_empty;
    usp_pkg::usp_pins_in_s pins_in;
    usp_pkg::usp_pins_out_s pins_out;
    int fails = 0, check_count = 0, ticks = 0;
    logic [33:0] r;
    usp_serial_pin_ctrl uut (.*);
    usp_line_model p (.aclk(aclk), .tx_line(pins_out.tx_serial_out), .pins(pins_in));
    // Clock and receive tick counter.
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) if (rx_clk_tick === 1'b1) ticks <= ticks + 1;
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One write (w=1) or read; r gets the response and read data.
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (k = 0; k < 200; k++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
                r = w ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (k == 200) begin
            fails++;
            final_report();
        end
    endtask : bus
    task automatic lv(input logic [7:0] v);
        @(posedge aclk);
        rx_fifo_level <= v;
        repeat (8) @(posedge aclk);
    endtask : lv
    task automatic tx_wait(input int n, input logic [7:0] exp);
        int k;
        for (k = 0; k < 3000 && p.n < n; k++) @(posedge aclk);
        if (k == 3000) begin
            fails++;
            final_report();
        end
        chk(p.got, exp);
    endtask : tx_wait
    task automatic t_reset();
        chk(pins_out, 5'h1f);
        bus(0, 8'h0c, 0);
        chk(r, 34'h10);
        bus(0, 8'h14, 0);
        chk(r, 34'h2060);
        bus(0, 8'h30, 0);
        chk(r, {2'h2, 32'h0});
    endtask : t_reset
    task automatic t_flow();
        bus(1, 8'h24, 2);
        lv(8'h60);
        chk(pins_out.request_to_send_n, 1);
        lv(8'h20);
        chk(pins_out.request_to_send_n, 1);
        lv(8'h1f);
        chk(pins_out.request_to_send_n, 0);
        bus(1, 8'h24, 32'h10);
        lv(8'h60);
        chk(pins_out.terminal_ready_n, 0);
        lv(8'h1f);
        chk(pins_out.terminal_ready_n, 1);
    endtask : t_flow
    task automatic t_stall();
        bus(1, 8'h24, 4);
        p.cts_n <= 1'b1;
        bus(1, 8'h18, 32'ha5);
        repeat (300) @(posedge aclk);
        chk(p.n, 0);
        bus(1, 8'h1c, 32'h13);
        tx_wait(1, 8'h13);
        p.cts_n <= 1'b0;
        tx_wait(2, 8'ha5);
        bus(1, 8'h24, 8);
        p.dsr_n <= 1'b1;
        bus(1, 8'h18, 32'h3c);
        repeat (300) @(posedge aclk);
        chk(p.n, 2);
        p.dsr_n <= 1'b0;
        tx_wait(3, 8'h3c);
    endtask : t_stall
    task automatic t_clock();
        int t0;
        t0 = ticks;
        p.burst();
        repeat (6) @(posedge aclk);
        chk(ticks - t0, 8);
        bus(1, 8'h08, 1);
        p.dsel = 1'b1;
        t0 = ticks;
        p.burst();
        repeat (6) @(posedge aclk);
        chk(ticks - t0, 8);
        bus(1, 8'h08, 6);
        repeat (4) @(posedge aclk);
        chk(pins_out.baud_clock_out_oe, 0);
        t0 = ticks;
        repeat (4) @(posedge aclk);
        chk(ticks - t0, 4);
    endtask : t_clock
    task automatic t_irda();
        @(posedge aclk);
        p.rxd <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(rx_serial_data, 0);
        bus(1, 8'h24, 1);
        bus(1, 8'h00, 32'h40);
        repeat (6) @(posedge aclk);
        chk(pins_out.tx_serial_out, 0);
        chk(rx_serial_data, 1);
        bus(1, 8'h04, 32'h18);
        repeat (3) @(posedge aclk);
        chk(pins_out.terminal_ready_n, 0);
    endtask : t_irda
    // Reset, then each scenario in turn.
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_flow();
        t_stall();
        t_clock();
        t_irda();
        final_report();
    end
endmodule : tb_uart_serial_pin_control
